// ### embi_regs.vh
// register offsets, field positions and reset values of the bus interface
`ifndef EMBI_REGS_VH
`define EMBI_REGS_VH
// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define EMBI_OFS_BANK_WIDTH 8'h00
`define EMBI_OFS_BANK_CYC 8'h04
`define EMBI_OFS_BANK_SIZE 8'h08
`define EMBI_OFS_MISC 8'h0c
`define EMBI_OFS_STATUS 8'h10
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define EMBI_MISC_HOLD_PREV 0
`define EMBI_WIDTH_8 2'b00
`define EMBI_WIDTH_16 2'b01
`define EMBI_WIDTH_32 2'b10
`define EMBI_STRAP_NAND 2'b00
`define EMBI_STRAP_16 2'b01
`define EMBI_STRAP_32 2'b10
`define EMBI_STRAP_TEST 2'b11
// ----------------------------------------
// reset values
// ----------------------------------------
`define EMBI_RST_BANK_WIDTH 32'h0000_aaaa
`define EMBI_RST_BANK_CYC 32'h7777_7777
`define EMBI_RST_BANK_SIZE 32'h0000_0000
`define EMBI_RST_MISC 32'h0000_0000
`endif

// ### embi_core.v
// external memory bus interface: wishbone registers plus static memory bus sequencer
// Overview of operation
// - strap pins captured on the first edge after reset, then frozen
// - strap picks nand boot or bank0 width
// - drive 27-bit address within bank
// - data bus driven on write, read otherwise
// - bank select low for addressed bank
// - write strobe low marks write cycle
// - read strobe low marks read cycle
// - hold grant only after bus released
// - cycle extend low stalls cycle completion
// - byte lane and write byte enables
// - granted bus: data floats, address and controls float or hold previous
`timescale 1ns/1ps
`default_nettype none
`include "embi_regs.vh"
module embi_core #(
  parameter ADDR_W = 27, // external address width
  parameter BANKS = 8 // number of banks
) (
  input wire clk, // 20 mhz system clock
  input wire arst_n, // async reset, active low
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [31:0] wb_adr_i, // byte address: bit 31 memory, else registers
  input wire [31:0] wb_dat_i, // write data
  input wire [3:0] wb_sel_i, // byte selects
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire [1:0] boot_strap_select, // boot strap pins
  output reg [ADDR_W-1:0] addr_o, // external address
  output reg [ADDR_W-1:0] addr_oe_n, // address output enables, low drives
  output reg [31:0] data_o, // external data out
  output reg [31:0] data_oe_n, // data output enables, low drives
  input wire [31:0] data_i, // external data in
  output reg [BANKS-1:0] bank_select_n, // bank selects
  output reg write_strobe_n, // write strobe
  output reg read_strobe_n, // read strobe
  output reg [3:0] byte_lane_enable_n, // byte lane enables
  output reg [3:0] write_byte_enable_n, // write byte enables
  output reg ctl_oe_n, // enable for selects, strobes and byte enables
  input wire hold_request_n, // other master wants bus
  output reg hold_grant_n, // bus handed over
  input wire cycle_extend_n, // wait input
  output reg [1:0] boot_mode, // captured strap value
  output reg nand_boot // strap chose nand boot
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 5'b00001; // between bus cycles
  localparam ST_SETUP = 5'b00010; // address and select out
  localparam ST_STROBE = 5'b00100; // strobe active, counting
  localparam ST_DONE = 5'b01000; // strobes released, answer
  localparam ST_HOLD = 5'b10000; // bus given to other master
  // ----------------------------------------
  // state, configuration and request decode
  // ----------------------------------------
  reg [4:0] state; // sequencer state
  reg strap_taken; // strap already latched
  reg [31:0] bank_width; // two bits per bank
  reg [31:0] bank_cyc; // four bits per bank: strobe cycles minus one
  reg [31:0] bank_size; // four bits per bank: region size code
  reg [31:0] misc_control_reg; // bit0 keeps previous levels when granted
  reg [3:0] cnt; // strobe cycle counter
  reg [2:0] cur_bank; // bank of current access
  wire [1:0] cur_width; // width code of current bank
  wire [3:0] sel_n_w; // active-low byte selects of request
  wire mem_req; // wishbone memory request
  wire reg_req; // wishbone register request
  wire [ADDR_W-1:0] in_bank; // address inside bank
  wire [2:0] req_bank; // bank addressed
  wire [31:0] sel_mask; // data byte mask
  wire hold_prev; // keep pins when granted
  wire [3:0] size_code; // size code of requested bank
  wire [ADDR_W-1:0] size_mask; // offset mask for bank size
  // ack low in the condition keeps a held request from being taken twice
  // limitation: a narrow bank is not split into several strobes, software must
  // keep its accesses within the bank's width
  assign mem_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[31];
  assign reg_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_adr_i[31];
  assign req_bank = wb_adr_i[29:27];
  assign size_code = bank_size[req_bank*4 +: 4];
  // size code n: bank offset limited to 2^(13+n) bytes, 14 and up means full 128 mbyte
  assign size_mask = (size_code >= 4'he) ? {ADDR_W{1'b1}} :
    ({{(ADDR_W-1){1'b0}}, 1'b1} << (5'd13 + {1'b0, size_code})) - {{(ADDR_W-1){1'b0}}, 1'b1};
  assign in_bank = wb_adr_i[ADDR_W-1:0] & size_mask;
  assign cur_width = bank_width[cur_bank*2 +: 2];
  assign sel_n_w = ~wb_sel_i;
  assign hold_prev = misc_control_reg[`EMBI_MISC_HOLD_PREV];
  // byte mask merges only the selected lanes into a register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_mask
      assign sel_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate
  // ----------------------------------------
  // strap capture and bank 0 width
  // ----------------------------------------
  // strap is latched on the first edge after release, never from the async branch
  // a strap change after that edge is ignored until the next reset
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_taken <= 1'b0;
      boot_mode <= 2'b00;
      nand_boot <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1; // frozen from here on
      boot_mode <= boot_strap_select;
      nand_boot <= (boot_strap_select == `EMBI_STRAP_NAND);
    end
  end
  // ----------------------------------------
  // registers and sequencer
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // pins idle after reset: controls high, data floated, address driven
      state <= ST_IDLE;
      bank_width <= `EMBI_RST_BANK_WIDTH;
      bank_cyc <= `EMBI_RST_BANK_CYC;
      bank_size <= `EMBI_RST_BANK_SIZE;
      misc_control_reg <= `EMBI_RST_MISC;
      cnt <= 4'h0;
      cur_bank <= 3'h0;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      addr_o <= {ADDR_W{1'b0}};
      addr_oe_n <= {ADDR_W{1'b0}};
      data_o <= 32'h0000_0000;
      data_oe_n <= 32'hffff_ffff;
      bank_select_n <= {BANKS{1'b1}};
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      byte_lane_enable_n <= 4'hf;
      write_byte_enable_n <= 4'hf;
      ctl_oe_n <= 1'b0;
      hold_grant_n <= 1'b1;
    end
    else
    begin
      // ack is a single-cycle pulse unless set again below
      wb_ack_o <= 1'b0;
      // bank 0 width follows the strap once, on the same edge that captures it
      if (!strap_taken)
      begin
        if (boot_strap_select == `EMBI_STRAP_16)
        begin
          bank_width[1:0] <= `EMBI_WIDTH_16;
        end
        else if (boot_strap_select == `EMBI_STRAP_32)
        begin
          bank_width[1:0] <= `EMBI_WIDTH_32;
        end
        else
        begin
          bank_width[1:0] <= `EMBI_WIDTH_8; // nand or test: bank 0 narrow
        end
      end
      // register access answers in one cycle, any state
      // no bus error exists: every register request is acked
      if (reg_req)
      begin
        wb_ack_o <= 1'b1;
        if (wb_adr_i[7:0] == `EMBI_OFS_BANK_WIDTH)
        begin
          if (wb_we_i)
            bank_width <= (bank_width & ~sel_mask) | (wb_dat_i & sel_mask);
          wb_dat_o <= bank_width;
        end
        else if (wb_adr_i[7:0] == `EMBI_OFS_BANK_CYC)
        begin
          if (wb_we_i)
            bank_cyc <= (bank_cyc & ~sel_mask) | (wb_dat_i & sel_mask);
          wb_dat_o <= bank_cyc;
        end
        else if (wb_adr_i[7:0] == `EMBI_OFS_BANK_SIZE)
        begin
          if (wb_we_i)
            bank_size <= (bank_size & ~sel_mask) | (wb_dat_i & sel_mask);
          wb_dat_o <= bank_size;
        end
        else if (wb_adr_i[7:0] == `EMBI_OFS_MISC)
        begin
          if (wb_we_i)
            misc_control_reg <= (misc_control_reg & ~sel_mask) | (wb_dat_i & sel_mask);
          wb_dat_o <= misc_control_reg;
        end
        else if (wb_adr_i[7:0] == `EMBI_OFS_STATUS)
        begin
          wb_dat_o <= {24'h000000, ~hold_grant_n, boot_mode, state}; // read only
        end
        else
        begin
          wb_dat_o <= 32'h0000_0000; // unmapped reads zero, writes dropped
        end
      end
      // ----------------------------------------
      // memory bus sequencer
      // ----------------------------------------
      case (state)
        ST_IDLE:
        begin
          // hold is only granted here, between cycles; it wins over a new access
          if (!hold_request_n)
          begin
            state <= ST_HOLD;
            hold_grant_n <= 1'b0;
            data_oe_n <= 32'hffff_ffff;
            // bit0 clear floats address and controls, bit0 set keeps driving their last levels; data floats either way
            addr_oe_n <= {ADDR_W{~hold_prev}};
            ctl_oe_n <= ~hold_prev;
          end
          // accesses start only here, so a grant never cuts one short
          else if (mem_req)
          begin
            state <= ST_SETUP;
            cur_bank <= req_bank;
            addr_o <= in_bank;
            bank_select_n <= ~({{(BANKS-1){1'b0}}, 1'b1} << req_bank);
            byte_lane_enable_n <= sel_n_w;
            cnt <= bank_cyc[req_bank*4 +: 4];
            if (wb_we_i)
            begin
              data_o <= wb_dat_i;
              data_oe_n <= 32'h0000_0000;
            end
          end
        end
        ST_SETUP:
        begin
          // strobe trails address and select by one cycle of setup
          state <= ST_STROBE;
          if (wb_we_i)
          begin
            write_strobe_n <= 1'b0;
            write_byte_enable_n <= sel_n_w;
          end
          else
          begin
            read_strobe_n <= 1'b0;
          end
        end
        ST_STROBE:
        begin
          // programmed extra strobe cycles run out before the wait input counts
          if (cnt != 4'h0)
          begin
            cnt <= cnt - 4'h1;
          end
          else if (cycle_extend_n)
          begin
            // completes only when the wait input is high
            state <= ST_DONE;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_byte_enable_n <= 4'hf;
            wb_ack_o <= 1'b1;
            // narrow banks return only their low lanes, upper lanes read zero
            if (cur_width == `EMBI_WIDTH_8)
              wb_dat_o <= {24'h000000, data_i[7:0]};
            else if (cur_width == `EMBI_WIDTH_16)
              wb_dat_o <= {16'h0000, data_i[15:0]};
            else
              wb_dat_o <= data_i;
          end
        end
        ST_DONE:
        begin
          // selects drop one cycle after strobes to give hold time
          state <= ST_IDLE;
          bank_select_n <= {BANKS{1'b1}};
          byte_lane_enable_n <= 4'hf;
          data_oe_n <= 32'hffff_ffff;
        end
        ST_HOLD:
        begin
          // request gone: take the pins back on the next cycle
          if (hold_request_n)
          begin
            state <= ST_IDLE;
            hold_grant_n <= 1'b1;
            addr_oe_n <= {ADDR_W{1'b0}};
            ctl_oe_n <= 1'b0;
          end
        end
        // an illegal state code falls back to idle
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // embi_core
`default_nettype wire

// ### embi_core_sva.sv
// assertion checker for the memory bus interface
`timescale 1ns/1ps
`default_nettype none
module embi_core_sva (
  input wire clk, // clock
  input wire arst_n, // reset
  input wire wb_ack_o, // ack
  input wire write_strobe_n, // write strobe
  input wire read_strobe_n, // read strobe
  input wire [7:0] bank_select_n, // selects
  input wire hold_request_n, // request in
  input wire hold_grant_n, // grant out
  input wire [31:0] data_oe_n, // data enables
  input wire [3:0] byte_lane_enable_n, // byte lanes
  input wire [3:0] write_byte_enable_n, // write byte lanes
  input wire cycle_extend_n, // wait in
  input wire [1:0] boot_mode, // strap copy
  input wire nand_boot // nand flag
);
  // ---
  // edges since reset; the strap lands one edge after release
  // ---
  reg [1:0] up;
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      up <= 2'd0;
    else if (up != 2'd3)
      up <= up + 2'd1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_keep; up[1] |-> $stable(boot_mode); endproperty
  a_keep: assert property (p_keep) else $error("strap copy moved");
  property p_nand; up[1] |-> nand_boot == (boot_mode == 2'b00); endproperty
  a_nand: assert property (p_nand) else $error("nand flag wrong");
  property p_one; $onehot0(~bank_select_n); endproperty
  a_one: assert property (p_one) else $error("two banks selected");
  property p_wr; !write_strobe_n |-> read_strobe_n && !(&bank_select_n) && !(&data_oe_n);
  endproperty
  a_wr: assert property (p_wr) else $error("bad write cycle");
  property p_rd; !read_strobe_n |-> write_strobe_n && !(&bank_select_n) && (&data_oe_n);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read cycle");
  property p_give; $fell(hold_grant_n) |-> (&bank_select_n) && write_strobe_n && read_strobe_n;
  endproperty
  a_give: assert property (p_give) else $error("grant mid cycle");
  property p_float; !hold_grant_n |-> (&data_oe_n) && (&bank_select_n); endproperty
  a_float: assert property (p_float) else $error("bus used while granted");
  property p_back; hold_request_n |=> hold_grant_n; endproperty
  a_back: assert property (p_back) else $error("grant kept");
  property p_stall; !cycle_extend_n && !(write_strobe_n && read_strobe_n) |=> !wb_ack_o;
  endproperty
  a_stall: assert property (p_stall) else $error("cycle ended in wait");
  property p_lane; !write_strobe_n |-> byte_lane_enable_n == write_byte_enable_n;
  endproperty
  a_lane: assert property (p_lane) else $error("byte lanes differ");
endmodule // embi_core_sva
bind embi_core embi_core_sva u_sva (.clk(clk), .arst_n(arst_n), .wb_ack_o(wb_ack_o),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .bank_select_n(bank_select_n), .hold_request_n(hold_request_n),
  .hold_grant_n(hold_grant_n), .data_oe_n(data_oe_n), .cycle_extend_n(cycle_extend_n),
  .byte_lane_enable_n(byte_lane_enable_n), .write_byte_enable_n(write_byte_enable_n),
  .boot_mode(boot_mode), .nand_boot(nand_boot));
`default_nettype wire

// ### embi_mem_model.sv
// static memory with wait states on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module embi_mem_model (
  input wire clk, // clock
  input wire [26:0] addr_o, // address
  input wire [31:0] data_o, // write data
  input wire [7:0] bank_select_n, // selects
  input wire write_strobe_n, // write strobe
  input wire read_strobe_n, // read strobe
  input wire [3:0] write_byte_enable_n, // byte writes
  input wire slow, // stretch each strobe
  output logic [31:0] data_i, // read data
  output logic cycle_extend_n, // wait out
  output logic [7:0] sel_seen // selects under strobe
);
  logic [31:0] mem [0:63];
  int wt = 0;
  wire busy = !(write_strobe_n && read_strobe_n);
  initial for (int i = 0; i < 64; i++) mem[i] = 0;
  always @(posedge clk)
  begin
    wt <= busy ? wt + 1 : 0;
    if (busy) sel_seen <= bank_select_n;
    for (int b = 0; b < 4; b++)
      if (!write_strobe_n && !write_byte_enable_n[b])
        mem[addr_o[7:2]][8 * b +: 8] <= data_o[8 * b +: 8];
  end
  // released lines float up to the pull-ups
  assign data_i = read_strobe_n ? 32'hffff_ffff : mem[addr_o[7:2]];
  assign cycle_extend_n = !(slow && busy && wt < 3);
endmodule // embi_mem_model
`default_nettype wire

// ### embi_core_test.sv
// self-checking bench for the memory bus interface
`timescale 1ns/1ps
`default_nettype none
module embi_core_test;
  logic clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, hold_request_n = 1, slow = 0;
  logic [31:0] adr = 0, dat = 0, rd, seed = 32'h20d8, refm [0:63];
  logic [3:0] sel = 0;
  logic [1:0] strap = 0;
  int num_errors = 0, comparisons = 0, cycles = 0, lat, nc[3] = '{7, 15, 0};
  wire [31:0] rdat, dout, doe_n, data_i;
  wire [26:0] addr, aoe_n;
  wire [7:0] bsel_n, seen;
  wire [3:0] wbe_n, ble_n;
  wire [1:0] bmode;
  wire ack, wr_n, rd_n, grant_n, ext_n, nboot, coe_n;
  embi_core DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .boot_strap_select(strap), .addr_o(addr), .addr_oe_n(aoe_n), .data_o(dout),
    .data_oe_n(doe_n), .data_i(data_i), .bank_select_n(bsel_n), .write_strobe_n(wr_n),
    .read_strobe_n(rd_n), .byte_lane_enable_n(ble_n), .write_byte_enable_n(wbe_n),
    .ctl_oe_n(coe_n),
    .hold_request_n(hold_request_n), .hold_grant_n(grant_n), .cycle_extend_n(ext_n),
    .boot_mode(bmode), .nand_boot(nboot));
  embi_mem_model u_mem (.clk(clk), .addr_o(addr), .data_o(dout), .bank_select_n(bsel_n),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .write_byte_enable_n(wbe_n), .slow(slow),
    .data_i(data_i), .cycle_extend_n(ext_n), .sel_seen(seen));
  initial forever #25 clk = ~clk;
  // ---
  // helpers: random source, compare, bus cycle, verdict
  // ---
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // hold the request until ack is sampled high, then release for one cycle
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    lat = 0;
    do @(posedge clk) lat++; while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  // write then read back one word; latency is 4 plus the bank's extra cycles
  task automatic mem(input logic [2:0] b, input logic [5:0] k, input int nx);
    logic [31:0] a = {2'b10, b, 19'h0, k, 2'b00};
    logic [31:0] d = rnd();
    logic [3:0] s = d[7:4] | 4'h1;
    wb(1, a, d, s);
    if (nx) chk(lat, nx);
    chk(seen, 8'(~(8'h01 << b)));
    chk(ble_n, 4'hf);
    for (int n = 0; n < 4; n++) if (s[n]) refm[k][8 * n +: 8] = d[8 * n +: 8];
    wb(0, a, 0, 4'hf);
    chk(rd, refm[k]);
    if (nx) chk(lat, nx);
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (++cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  initial
  begin
    for (int i = 0; i < 64; i++) refm[i] = 0;
    for (int i = 3; i < 7; i++)
    begin
      strap <= i[1:0];
      arst_n <= 0;
      repeat (3) @(posedge clk);
      arst_n <= 1;
      repeat (2) @(posedge clk);
      chk(bmode, i[1:0]);
      chk(nboot, i == 4);
      strap <= ~strap;
      repeat (2) @(posedge clk);
      chk(bmode, i[1:0]);
    end
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5) wb(1, 32'h20, rnd(), 4'hf);
      wb(0, i < 4 ? 4 * i : 32'h20, 0, 4'hf);
      chk(rd, i == 0 ? 32'haaaa : i == 1 ? 32'h7777_7777 : 0);
    end
    foreach (nc[j])
    begin
      wb(1, 4, {8{nc[j][3:0]}}, 4'hf);
      for (int k = 0; k < 4; k++) mem(rnd(), k, nc[j] + 4);
    end
    slow <= 1;
    mem(7, 9, 0);
    chk(lat > 5, 1);
    slow <= 0;
    for (int m = 0; m < 2; m++)
    begin
      wb(1, 32'hc, m, 4'hf);
      fork
        wb(1, 32'h8800_0000, rnd(), 4'hf);
        begin
          repeat (2) @(posedge clk);
          hold_request_n <= 0;
        end
      join
      chk(lat, 4);
      while (grant_n !== 1'b0 && lat < 30) @(posedge clk) lat++;
      chk(grant_n, 0);
      chk(aoe_n, m ? 0 : 32'h07ff_ffff);
      chk(coe_n, m ? 0 : 1);
      wb(0, 32'h10, 0, 4'hf);
      chk(rd, 32'hd0);
      chk(doe_n, 32'hffff_ffff);
      hold_request_n <= 1;
      repeat (2) @(posedge clk);
      chk(grant_n, 1);
    end
    conclude();
  end
endmodule // embi_core_test
`default_nettype wire
